// File: verilog/fdm_device.sv
// device end: mode controller of the flash disk on the host memory bus
`timescale 1ns/1ps
module fdm_device
  import fdm_pkg::*;
#(
  parameter logic [FDM_DW-1:0] SERIAL_WORD = 16'h5a5a // arbitrary value
) (
  input  wire logic  sys_clk,
  input  wire logic  rst,
  fdm_bus_if.device  bus,
  output fdm_mode_t  mode,
  output logic       inputsGated,
  output logic [7:0] scratch
);
  // ---------------------------------------------------------------
  // pin capture
  // ---------------------------------------------------------------
  logic [12:0] addrS;
  logic [15:0] dataS;
  logic        csnS, wenS, oenS, avdnS, rstnS, pdpS, muxS;
  logic        gate;

  // gated buffers: while asleep and deselected, address, data and strobe inputs are held idle
  logic [12:0] addrG;
  logic [15:0] dataG;
  logic        wenG, oenG, avdnG;
  assign gate  = (mode == FDM_PDOWN) && bus.chipSel_n;
  assign addrG = gate ? '0 : bus.addr;
  assign dataG = gate ? '0 : bus.dataH2d;
  assign wenG  = gate | bus.writeStb_n;
  assign oenG  = gate | bus.outEn_n;
  assign avdnG = gate | bus.address_valid_strobe_n;

  // idle levels; power-down pin low and standard bus, so no false edge after reset
  fdm_sync #(.W(36), .INIT({13'h0, 16'h0, 7'h7c})) uSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   ({addrG, dataG, bus.chipSel_n, wenG, oenG, avdnG, bus.hw_reset_input_n,
               bus.power_down_toggle_pin, bus.multiplexed}),
    .pinSync ({addrS, dataS, csnS, wenS, oenS, avdnS, rstnS, pdpS, muxS})
  );

  // ---------------------------------------------------------------
  // cycle decode
  // ---------------------------------------------------------------
  logic wrAct, rdAct, wrAct_r, rdAct_r, wrStart, rdEnd, csRise;
  logic csn_r, pdp_r, rstn_r;
  logic [12:0] aLatch_r;
  assign wrAct   = !csnS && !wenS;
  assign rdAct   = !csnS && !oenS;
  assign wrStart = wrAct && !wrAct_r;
  assign rdEnd   = !rdAct && rdAct_r;
  assign csRise  = csnS && !csn_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrAct_r <= 1'b0;
      rdAct_r <= 1'b0;
      csn_r   <= 1'b1;
      pdp_r   <= 1'b0;
      rstn_r  <= 1'b1;
    end else begin
      wrAct_r <= wrAct;
      rdAct_r <= rdAct;
      csn_r   <= csnS;
      pdp_r   <= pdpS;
      rstn_r  <= rstnS;
    end
  end

  // multiplexed bus: address latched while the valid strobe is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) aLatch_r <= '0;
    else if (!muxS || !avdnS) aLatch_r <= muxS ? dataS[12:0] : addrS;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r, pdCtl_r;
  logic       armPd_r, inNormalCmd;
  logic [2:0] wakeCnt_r;
  logic [7:0] extCnt_r;
  logic       extWake;
  logic [1:0] pdEdge;
  logic       pinWake, hwHeld;

  // power-up boot detector: async reset is the power-up event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= FDM_RESET;
    end else if (!rstnS) begin
      mode <= (mode == FDM_NORMAL || mode == FDM_PDOWN) && !rstn_r ? FDM_PDOWN :
              (mode == FDM_NORMAL ? FDM_PDOWN : FDM_RESET);
    end else if (!rstn_r) begin
      mode <= FDM_RESET;
    end else begin
      case (mode)
        FDM_RESET: begin
          if (wrStart && addrCur() == FDM_ADDR_CONF && fdm_confirm_ok(ctrl_r, dataS) &&
              fdm_code({8'h00, ctrl_r}) == FDM_CODE_NORMAL)
            mode <= FDM_NORMAL;
        end
        FDM_NORMAL: begin
          if (wrStart && addrCur() == FDM_ADDR_CONF && fdm_confirm_ok(ctrl_r, dataS) &&
              fdm_code({8'h00, ctrl_r}) == FDM_CODE_RESET)
            mode <= FDM_RESET;
          else if (armPd_r && csRise)
            mode <= FDM_PDOWN;
        end
        FDM_PDOWN: begin
          if (wakeCnt_r == FDM_WAKE_READS || extWake || pinWake)
            mode <= FDM_NORMAL;
        end
        default: mode <= FDM_RESET;
      endcase
    end
  end

  function automatic logic [12:0] addrCur();
    return muxS ? aLatch_r : addrS;
  endfunction : addrCur

  // hardware reset wins over the software write sequence; its edge counts even if held
  assign hwHeld      = !rstnS;
  assign inNormalCmd = fdm_code({8'h00, ctrl_r}) == FDM_CODE_PDOWN;

  // control, confirmation, power-down control and scratch writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r  <= '0;
      pdCtl_r <= {6'h0, FDM_PDCTL_RST};
      scratch <= '0;
      armPd_r <= 1'b0;
    end else if (wrStart && mode != FDM_PDOWN) begin
      if (addrCur() == FDM_ADDR_CTRL) ctrl_r <= dataS[7:0];
      if (addrCur() == FDM_ADDR_CONF && mode == FDM_NORMAL)
        armPd_r <= fdm_confirm_ok(ctrl_r, dataS) && inNormalCmd;
      if (mode == FDM_NORMAL && addrCur() == FDM_ADDR_PDCTL) pdCtl_r <= dataS[7:0];
      if (mode == FDM_NORMAL && addrCur() == FDM_ADDR_SCR) scratch <= dataS[7:0];
    end else if (mode != FDM_NORMAL) begin
      armPd_r <= 1'b0;
    end
  end

  // wake by repeated reads of the top boot-block word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) wakeCnt_r <= '0;
    else if (mode != FDM_PDOWN) wakeCnt_r <= '0;
    else if (rdEnd && addrCur() == FDM_ADDR_WAKE && wakeCnt_r != FDM_WAKE_READS)
      wakeCnt_r <= wakeCnt_r + 3'h1;
  end

  // long strobe on the standard bus wakes in a single read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) extCnt_r <= '0;
    else if (mode != FDM_PDOWN || !rdAct || muxS || !bootAddr(addrCur())) extCnt_r <= '0;
    else if (extCnt_r != 8'(FDM_EXT_CYC)) extCnt_r <= extCnt_r + 8'h1;
  end
  assign extWake = extCnt_r == 8'(FDM_EXT_CYC);

  assign pdEdge  = {pdpS && !pdp_r, !pdpS && pdp_r};
  assign pinWake = pdCtl_r[FDM_PD_EN_BIT] &&
                   (pdCtl_r[FDM_PD_RISE_BIT] ? pdEdge[1] : pdEdge[0]);

  function automatic logic bootAddr(input logic [12:0] a);
    return a < FDM_REG_LO || a > FDM_REG_HI;
  endfunction : bootAddr

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // boot-block contents are outside this block; a fixed word stands in
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus.dataD2h <= '0;
      bus.dataOe  <= 1'b0;
    end else begin
      bus.dataOe <= rdAct && mode != FDM_PDOWN;
      if (bootAddr(addrCur()))
        bus.dataD2h <= SERIAL_WORD;
      else if (mode != FDM_NORMAL)
        bus.dataD2h <= {8'h00, FDM_ZERO_BYTE};
      else if (addrCur() == FDM_ADDR_CTRL)
        bus.dataD2h <= {8'h00, ctrl_r[7:2], modeCode(mode)};
      else if (addrCur() == FDM_ADDR_PDCTL)
        bus.dataD2h <= {8'h00, pdCtl_r};
      else if (addrCur() == FDM_ADDR_SCR)
        bus.dataD2h <= {8'h00, scratch};
      else
        bus.dataD2h <= '0;
    end
  end

  function automatic logic [1:0] modeCode(input fdm_mode_t m);
    return m == FDM_NORMAL ? FDM_CODE_NORMAL : (m == FDM_PDOWN ? FDM_CODE_PDOWN : FDM_CODE_RESET);
  endfunction : modeCode

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus.busy_n  <= 1'b0;
      inputsGated <= 1'b0;
    end else begin
      bus.busy_n  <= !hwHeld;
      inputsGated <= gate;
    end
  end
endmodule : fdm_device

// File: verilog/fdm_pkg.sv
// package: constants and types for the flash disk mode controller
package fdm_pkg;
  // operating modes as seen through the mode control register
  typedef enum logic [1:0] {
    FDM_NORMAL,
    FDM_RESET,
    FDM_PDOWN
  } fdm_mode_t;

  localparam int          FDM_AW          = 13;
  localparam int          FDM_DW          = 16;
  // register window
  localparam logic [12:0] FDM_ADDR_CTRL   = 13'h100c;
  localparam logic [12:0] FDM_ADDR_CONF   = 13'h1072;
  localparam logic [12:0] FDM_ADDR_PDCTL  = 13'h107c;
  localparam logic [12:0] FDM_ADDR_SCR    = 13'h1040;
  localparam logic [12:0] FDM_ADDR_WAKE   = 13'h1fff;
  localparam logic [12:0] FDM_REG_LO      = 13'h0800;
  localparam logic [12:0] FDM_REG_HI      = 13'h17ff;
  // mode control field codes
  localparam logic [1:0]  FDM_CODE_NORMAL = 2'h1;
  localparam logic [1:0]  FDM_CODE_RESET  = 2'h0;
  localparam logic [1:0]  FDM_CODE_PDOWN  = 2'h2;
  localparam logic [7:0]  FDM_ZERO_BYTE   = 8'h00;
  localparam logic [2:0]  FDM_WAKE_READS  = 3'h4;
  // power-down pin modes: bit0 enables pin wake, bit1 selects rising edge
  localparam logic [1:0]  FDM_PDCTL_RST   = 2'h0;
  localparam int          FDM_PD_EN_BIT   = 0;
  localparam int          FDM_PD_RISE_BIT = 1;
  // extended boot-block read wake: strobe held this many cycles
  localparam int          FDM_EXT_NS      = 200;
  localparam int          FDM_CLK_MHZ     = 40;
  localparam int          FDM_EXT_CYC     = (FDM_EXT_NS * FDM_CLK_MHZ + 999) / 1000;
  // boot image layout
  localparam int          FDM_BOOT_BYTES  = 2048;
  localparam int          FDM_BOOT_BLK    = 3;
  localparam int          FDM_BOOT_COPY   = 4;
  localparam int          FDM_SN_BYTES    = 16;

  // mode code from the control register byte
  function automatic logic [1:0] fdm_code(input logic [FDM_DW-1:0] d);
    return d[1:0];
  endfunction : fdm_code

  // confirmation byte is the complement of the control byte
  function automatic logic fdm_confirm_ok(input logic [7:0] ctrl, input logic [FDM_DW-1:0] d);
    return d[7:0] == ~ctrl;
  endfunction : fdm_confirm_ok
endpackage : fdm_pkg

// File: verilog/fdm_bus_if.sv
// interface: host asynchronous memory bus between host and device
`timescale 1ns/1ps
interface fdm_bus_if;
  logic [12:0] addr;
  logic [15:0] dataH2d;
  logic [15:0] dataD2h;
  logic        dataOe;
  logic        chipSel_n;
  logic        writeStb_n;
  logic        outEn_n;
  logic        address_valid_strobe_n;
  logic        hw_reset_input_n;
  logic        power_down_toggle_pin;
  logic        busy_n;
  logic        multiplexed;

  modport device (
    input  addr, dataH2d, chipSel_n, writeStb_n, outEn_n, address_valid_strobe_n,
    input  hw_reset_input_n, power_down_toggle_pin, multiplexed,
    output dataD2h, dataOe, busy_n
  );
  modport host (
    output addr, dataH2d, chipSel_n, writeStb_n, outEn_n, address_valid_strobe_n,
    output hw_reset_input_n, power_down_toggle_pin, multiplexed,
    input  dataD2h, dataOe, busy_n
  );
endinterface : fdm_bus_if

// File: verilog/fdm_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module fdm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r  <= INIT;
      pinSync <= INIT;
    end else begin
      meta_r  <= pinIn;
      pinSync <= meta_r;
    end
  end
endmodule : fdm_sync

// File: verilog/fdm_host.sv
// host end: drives mode sequences onto the memory bus
`timescale 1ns/1ps
module fdm_host
  import fdm_pkg::*;
#(
  // strobe must outlast two sync flops each way plus the device data register
  parameter int STROBE_CYC = 5,
  parameter int LONG_CYC   = FDM_EXT_CYC + 6
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  fdm_bus_if.host          bus,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic        reqLong,
  input  wire logic [12:0] reqAddr,
  input  wire logic [15:0] reqData,
  input  wire logic        hwReset,
  input  wire logic        pdPin,
  output logic             reqReady,
  output logic             rspValid,
  output logic [15:0]      rspData
);
  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_GAP} fdm_hst_t;
  fdm_hst_t st_r;
  logic [7:0] cnt_r;
  logic       isWr_r;
  logic       oe_s1, oe_s2;
  logic [15:0] d_s1, d_s2;

  // device data crosses in from the bus pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_s1 <= 1'b0;
      oe_s2 <= 1'b0;
      d_s1  <= '0;
      d_s2  <= '0;
    end else begin
      oe_s1 <= bus.dataOe;
      oe_s2 <= oe_s1;
      d_s1  <= bus.dataD2h;
      d_s2  <= d_s1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r                       <= H_IDLE;
      cnt_r                      <= '0;
      isWr_r                     <= 1'b0;
      bus.addr                   <= '0;
      bus.dataH2d                <= '0;
      bus.chipSel_n              <= 1'b1;
      bus.writeStb_n             <= 1'b1;
      bus.outEn_n                <= 1'b1;
      bus.address_valid_strobe_n <= 1'b1;
      bus.multiplexed            <= 1'b0;
      reqReady                   <= 1'b0;
      rspValid                   <= 1'b0;
      rspData                    <= '0;
    end else begin
      rspValid <= 1'b0;
      case (st_r)
        H_IDLE: begin
          reqReady <= 1'b1;
          if (reqValid && reqReady) begin
            reqReady       <= 1'b0;
            isWr_r         <= reqWrite;
            bus.addr       <= reqAddr;
            bus.dataH2d    <= reqData;
            bus.chipSel_n  <= 1'b0;
            bus.writeStb_n <= !reqWrite;
            bus.outEn_n    <= reqWrite;
            cnt_r          <= reqLong ? 8'(LONG_CYC) : 8'(STROBE_CYC);
            st_r           <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (cnt_r == 8'h0) begin
            bus.writeStb_n <= 1'b1;
            bus.outEn_n    <= 1'b1;
            rspData        <= oe_s2 ? d_s2 : '0;
            rspValid       <= !isWr_r;
            cnt_r          <= 8'(STROBE_CYC);
            st_r           <= H_GAP;
          end else begin
            cnt_r <= cnt_r - 8'h1;
          end
        end
        H_GAP: begin
          // address held past the strobe; chip select negation commits power-down
          bus.chipSel_n <= 1'b1;
          if (cnt_r == 8'h0) st_r <= H_IDLE;
          else cnt_r <= cnt_r - 8'h1;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // reset and power-down pins follow their requests; are host sequencing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus.hw_reset_input_n      <= 1'b0;
      bus.power_down_toggle_pin <= 1'b0;
    end else begin
      bus.hw_reset_input_n      <= !hwReset;
      bus.power_down_toggle_pin <= pdPin;
    end
  end
endmodule : fdm_host

// File: testbench/fdm_props.sv
// checker: mode controller behaviour seen on the host bus
`timescale 1ns/1ps
module fdm_props
  import fdm_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [12:0] addr,
  input wire logic        dataOe,
  input wire logic        chipSel_n,
  input wire logic        outEn_n,
  input wire logic        hw_reset_input_n,
  input wire logic        busy_n,
  input wire fdm_mode_t   mode,
  input wire logic        inputsGated,
  input wire logic [7:0]  scratch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // mode relations
  // ------------------------------------------------------------
  mode_legal_a: assert property (mode inside {FDM_NORMAL, FDM_RESET, FDM_PDOWN})
    else $error("mode holds an illegal value");
  // pin passes two sync flops, so allow a few edges of lag
  pin_hold_a: assert property ((!hw_reset_input_n) [*4] |-> mode != FDM_NORMAL)
    else $error("mode stayed normal under reset pin");
  pin_release_a: assert property ($rose(hw_reset_input_n) |-> ##[1:5] mode == FDM_RESET)
    else $error("reset pin release did not give reset mode");
  busy_hold_a: assert property ((!hw_reset_input_n) [*4] |-> !busy_n)
    else $error("busy not shown while reset pin held");
  normal_entry_a: assert property (mode == FDM_NORMAL && $past(mode) == FDM_RESET
    |-> !chipSel_n && addr == FDM_ADDR_CONF)
    else $error("normal entered without confirmation write");
  pdown_entry_a: assert property (mode == FDM_PDOWN && $past(mode) == FDM_NORMAL |-> chipSel_n)
    else $error("power-down entered while selected");
  pdown_quiet_a: assert property (mode == FDM_PDOWN |-> !dataOe)
    else $error("data bus driven in power-down");
  gate_only_a: assert property (inputsGated |-> mode == FDM_PDOWN || $past(mode) == FDM_PDOWN)
    else $error("inputs gated while awake");
  gate_asleep_a: assert property ((mode == FDM_PDOWN && chipSel_n) [*4] |-> inputsGated)
    else $error("inputs not gated while asleep");
  scratch_keep_a: assert property (mode != FDM_NORMAL && $past(mode) != FDM_NORMAL
    |-> $stable(scratch))
    else $error("scratch changed outside normal mode");
  read_drive_a: assert property ($rose(dataOe) |-> !$past(outEn_n) && !$past(chipSel_n))
    else $error("data driven without a read cycle");
endmodule : fdm_props

// File: testbench/flash_disk_mode_controller_tb.sv
// testbench: host and device ends joined on the memory bus
`timescale 1ns/1ps
module flash_disk_mode_controller_tb
  import fdm_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [12:0] a;
    logic [15:0] d;
    fdm_mode_t   m;
    logic [15:0] msk;
    logic [15:0] exp;
  } fdm_row_t;

  localparam logic [15:0] SN_WORD = 16'h2b6c; // arbitrary value

  logic        sys_clk;
  logic        rst;
  logic        reqValid;
  logic        reqWrite;
  logic        reqLong;
  logic [12:0] reqAddr;
  logic [15:0] reqData;
  logic        hwReset;
  logic        pdPin;
  logic        reqReady;
  logic        rspValid;
  logic [15:0] rspData;
  logic [15:0] rsp;
  fdm_mode_t   mode;
  logic        inputsGated;
  logic [7:0]  scratch;
  fdm_row_t    rows [19];
  int          n_fail;
  int          samples_checked;
  int          cycles;

  fdm_bus_if bus ();

  fdm_device #(.SERIAL_WORD(SN_WORD)) u_fdm_device (.sys_clk(sys_clk), .rst(rst), .bus(bus), .mode(mode),
    .inputsGated(inputsGated), .scratch(scratch));
  fdm_host u_fdm_host (.sys_clk(sys_clk), .rst(rst), .bus(bus), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqLong(reqLong), .reqAddr(reqAddr), .reqData(reqData), .hwReset(hwReset), .pdPin(pdPin),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
  fdm_props u_fdm_props (.sys_clk(sys_clk), .rst(rst), .addr(bus.addr), .dataOe(bus.dataOe),
    .chipSel_n(bus.chipSel_n), .outEn_n(bus.outEn_n), .hw_reset_input_n(bus.hw_reset_input_n),
    .busy_n(bus.busy_n), .mode(mode), .inputsGated(inputsGated), .scratch(scratch));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // long settle: chip select lingers after the strobe, then two sync flops
  task automatic xfer(input logic wr, input logic lng, input logic [12:0] a, input logic [15:0] d);
    int k;
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqLong  <= lng;
    reqAddr  <= a;
    reqData  <= d;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (reqReady !== 1'b1 && k < 60);
    reqValid <= 1'b0;
    k = 0;
    // writes give no response pulse; their end is the host ready again
    do begin @(posedge sys_clk); k++; end while ((wr ? reqReady : rspValid) !== 1'b1 && k < 60);
    rsp = rspData;
    chk("answer", 16'h1, {15'h0, k < 60});
    repeat (14) @(posedge sys_clk);
  endtask : xfer

  task automatic enter(input logic [1:0] code);
    xfer(1'b1, 1'b0, FDM_ADDR_CTRL, {14'h0, code});
    xfer(1'b1, 1'b0, FDM_ADDR_CONF, {8'h0, ~{6'h0, code}});
  endtask : enter

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    rst      = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqLong  = 1'b0;
    reqAddr  = 13'h0;
    reqData  = 16'h0;
    hwReset  = 1'b0;
    pdPin    = 1'b0;
    rows = '{
      '{1'b0, FDM_ADDR_CTRL, 16'h0, FDM_RESET, 16'hffff, 16'h0},
      '{1'b1, FDM_ADDR_CTRL, 16'h1, FDM_RESET, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CONF, 16'hfe, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_SCR, 16'h3c, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b0, FDM_ADDR_CTRL, 16'h0, FDM_NORMAL, 16'h3, 16'h1},
      '{1'b1, FDM_ADDR_CTRL, 16'h0, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CONF, 16'h0, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CTRL, 16'h0, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CONF, 16'hff, FDM_RESET, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_SCR, 16'h77, FDM_RESET, 16'h0, 16'h0},
      '{1'b0, FDM_ADDR_SCR, 16'h0, FDM_RESET, 16'hffff, 16'h0},
      '{1'b1, FDM_ADDR_CTRL, 16'h1, FDM_RESET, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CONF, 16'hfe, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CTRL, 16'h2, FDM_NORMAL, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_CONF, 16'hfd, FDM_PDOWN, 16'h0, 16'h0},
      '{1'b1, FDM_ADDR_SCR, 16'h11, FDM_PDOWN, 16'h0, 16'h0},
      '{1'b0, FDM_ADDR_WAKE, 16'h0, FDM_PDOWN, 16'h0, 16'h0},
      '{1'b0, FDM_ADDR_WAKE, 16'h0, FDM_PDOWN, 16'h0, 16'h0},
      '{1'b0, FDM_ADDR_WAKE, 16'h0, FDM_PDOWN, 16'h0, 16'h0}};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    foreach (rows[i]) begin
      xfer(rows[i].wr, 1'b0, rows[i].a, rows[i].d);
      chk("mode", 16'(rows[i].m), 16'(mode));
      if (rows[i].msk !== 16'h0) begin
        chk("rdata", rows[i].exp, rsp & rows[i].msk);
      end
    end
    // fourth wake read, then the scratch value must have survived
    xfer(1'b0, 1'b0, FDM_ADDR_WAKE, 16'h0);
    chk("mode", 16'(FDM_NORMAL), 16'(mode));
    xfer(1'b0, 1'b0, FDM_ADDR_SCR, 16'h0);
    chk("rdata", 16'h3c, rsp & 16'hff);
    chk("scratch", 16'h3c, {8'h0, scratch});
    hwReset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("mode", 16'(FDM_PDOWN), 16'(mode));
    chk("busy", 16'h0, {15'h0, bus.busy_n});
    hwReset <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("mode", 16'(FDM_RESET), 16'(mode));
    enter(FDM_CODE_NORMAL);
    enter(FDM_CODE_PDOWN);
    xfer(1'b0, 1'b1, 13'h0010, 16'h0);
    chk("mode", 16'(FDM_NORMAL), 16'(mode));
    chk("rdata", SN_WORD, rsp);
    // rising then falling pin wake; two stray wake reads each time
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, 1'b0, FDM_ADDR_PDCTL, (i == 0) ? 16'h3 : 16'h1);
      enter(FDM_CODE_PDOWN);
      chk("gated", 16'h1, {15'h0, inputsGated});
      xfer(1'b0, 1'b0, FDM_ADDR_WAKE, 16'h0);
      xfer(1'b0, 1'b0, FDM_ADDR_WAKE, 16'h0);
      pdPin <= (i == 0);
      repeat (10) @(posedge sys_clk);
      chk("mode", 16'(FDM_NORMAL), 16'(mode));
    end
    enter(FDM_CODE_PDOWN);
    repeat (3) xfer(1'b0, 1'b0, FDM_ADDR_WAKE, 16'h0);
    chk("mode", 16'(FDM_PDOWN), 16'(mode));
    xfer(1'b0, 1'b0, FDM_ADDR_WAKE, 16'h0);
    chk("mode", 16'(FDM_NORMAL), 16'(mode));
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("mode", 16'(FDM_RESET), 16'(mode));
    stop_test();
  end
endmodule : flash_disk_mode_controller_tb
